// File: hw/tso_defines.vh
// Constants for the touch sense oscillator control block
`ifndef TSO_DEFINES_VH
`define TSO_DEFINES_VH
`define TSO_ADDR_CTRL      12'h000
`define TSO_ADDR_CHAN      12'h004
`define TSO_ADDR_TMR_A     12'h008
`define TSO_ADDR_TMR_B     12'h00c
`define TSO_ADDR_TCFG      12'h010
`define TSO_ADDR_STAT      12'h014
`define TSO_BIT_ENABLE     7
`define TSO_BIT_RANGE_HI   3
`define TSO_BIT_RANGE_LO   2
`define TSO_BIT_DIR        1
`define TSO_BIT_EXTSEL     0
`define TSO_BIT_TA_SRC     0
`define TSO_BIT_TB_SRC_LO  1
`define TSO_BIT_TB_SRC_HI  2
`define TSO_BIT_TA_RUN     3
`define TSO_BIT_TB_RUN     4
`define TSO_RANGE_OFF      2'h0
`define TSO_TB_SRC_OSC     2'h3
`define TSO_CHAN_LAST      4'hb
`define TSO_RESET_BYTE     8'h00
`define TSO_RESET_WORD     32'h0000_0000
`define TSO_FOSC_DIV       2'h3
`endif

// File: hw/tso_edge_sync.v
// Two-flop synchroniser with rising-edge pulse output
module tso_edge_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire ce,
    input  wire din,
    output wire rise
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Stage chain, only s2 onward is looked at
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = ce & s2_q & ~s3_q;
endmodule // tso_edge_sync

// File: hw/tso_top.v
// Touch sense oscillator control with APB registers and two counters
`include "tso_defines.vh"
module tso_top #(
    parameter NCH   = 12,
    parameter TW    = 16
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              ce,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              sleep,
    input  wire              osc_wave,
    input  wire              osc_sourcing,
    input  wire              timer_a_clock_pin,
    output wire              osc_run,
    output wire [1:0]        osc_current_range,
    output wire [NCH-1:0]    sense_input_pin,
    output wire [TW-1:0]     timer_a_count,
    output wire [TW-1:0]     timer_b_count
);
    reg  [3:0]    sense_channel_code_q;
    reg           sense_unit_enable_q;
    reg  [1:0]    osc_current_range_q;
    reg           osc_direction_flag_q;
    reg           timer_a_ext_clock_select_q;
    reg           timer_a_clock_source_q;
    reg  [1:0]    timer_b_clock_source_q;
    reg           ta_run_q;
    reg           tb_run_q;
    reg  [TW-1:0] ta_q;
    reg  [TW-1:0] tb_q;
    reg  [1:0]    fosc_div_q;
    reg  [NCH-1:0] chan_sel_q;
    wire          osc_edge;
    wire          pin_edge;
    wire          wr;
    wire          rd;
    wire          mapped;
    wire          osc_active;
    wire          ta_tick;
    wire          tb_tick;
    wire          fosc_tick;
    wire          ta_wr;
    wire          tb_wr;
    reg  [7:0]    ctrl_rd;

    // Oscillator only counts as live when enabled and range nonzero
    assign osc_active = sense_unit_enable_q
                      & (osc_current_range_q != `TSO_RANGE_OFF);
    // Runs independent of sleep
    assign osc_run = osc_active;
    assign osc_current_range = osc_current_range_q;
    assign sense_input_pin = chan_sel_q;

    // Edge detection of the oscillator and the pin clock
    tso_edge_sync u_osc_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (osc_wave),
        .rise    (osc_edge)
    );

    tso_edge_sync u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (timer_a_clock_pin),
        .rise    (pin_edge)
    );

    // One-hot channel decode
    function [NCH-1:0] chan_decode;
        input       en;
        input [3:0] code;
        integer     i;
        begin
            chan_decode = {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                if (en && (code == i[3:0])) begin
                    chan_decode[i] = 1'b1;
                end
            end
        end
    endfunction

    // Registered mux selection; nothing selected while disabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_sel_q <= {NCH{1'b0}};
        end else if (ce) begin
            chan_sel_q <= chan_decode(sense_unit_enable_q, sense_channel_code_q);
        end
    end

    // Quarter-rate tick for the internal timer source
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fosc_div_q <= 2'h0;
        end else if (ce) begin
            fosc_div_q <= fosc_div_q + 2'h1;
        end
    end
    assign fosc_tick = ce & (fosc_div_q == `TSO_FOSC_DIV);

    // Timer A source select and sleep gating
    assign ta_tick = ta_run_q & ~sleep
                   & (timer_a_clock_source_q
                      ? (timer_a_ext_clock_select_q ? (osc_edge & osc_active)
                                                    : pin_edge)
                      : fosc_tick);
    // Timer B counts oscillations, also in sleep
    assign tb_tick = tb_run_q & osc_edge & osc_active
                   & (timer_b_clock_source_q == `TSO_TB_SRC_OSC);

    // Bus strobes
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == `TSO_ADDR_CTRL) | (paddr == `TSO_ADDR_CHAN)
                   | (paddr == `TSO_ADDR_TMR_A) | (paddr == `TSO_ADDR_TMR_B)
                   | (paddr == `TSO_ADDR_TCFG) | (paddr == `TSO_ADDR_STAT);
    assign pslverr = psel & penable & ~mapped;
    assign ta_wr   = wr & (paddr == `TSO_ADDR_TMR_A);
    assign tb_wr   = wr & (paddr == `TSO_ADDR_TMR_B);

    // Control and channel registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_unit_enable_q        <= 1'b0;
            osc_current_range_q        <= `TSO_RANGE_OFF;
            timer_a_ext_clock_select_q <= 1'b0;
            sense_channel_code_q       <= 4'h0;
            timer_a_clock_source_q     <= 1'b0;
            timer_b_clock_source_q     <= 2'h0;
            ta_run_q                   <= 1'b0;
            tb_run_q                   <= 1'b0;
        end else if (ce && wr) begin
            case (paddr)
                `TSO_ADDR_CTRL: begin
                    sense_unit_enable_q        <= pwdata[`TSO_BIT_ENABLE];
                    osc_current_range_q        <= pwdata[`TSO_BIT_RANGE_HI:`TSO_BIT_RANGE_LO];
                    timer_a_ext_clock_select_q <= pwdata[`TSO_BIT_EXTSEL];
                end
                `TSO_ADDR_CHAN: begin
                    sense_channel_code_q <= pwdata[3:0];
                end
                `TSO_ADDR_TCFG: begin
                    timer_a_clock_source_q <= pwdata[`TSO_BIT_TA_SRC];
                    timer_b_clock_source_q <= pwdata[`TSO_BIT_TB_SRC_HI:`TSO_BIT_TB_SRC_LO];
                    ta_run_q               <= pwdata[`TSO_BIT_TA_RUN];
                    tb_run_q               <= pwdata[`TSO_BIT_TB_RUN];
                end
                default: begin
                    sense_unit_enable_q <= sense_unit_enable_q;
                end
            endcase
        end
    end

    // Direction flag follows oscillator only while it runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_direction_flag_q <= 1'b0;
        end else if (ce && osc_active) begin
            osc_direction_flag_q <= osc_sourcing;
        end
    end

    // Counters: software write wins, else one step per tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_q <= {TW{1'b0}};
            tb_q <= {TW{1'b0}};
        end else if (ce) begin
            if (ta_wr) begin
                ta_q <= pwdata[TW-1:0];
            end else if (ta_tick) begin
                ta_q <= ta_q + {{(TW-1){1'b0}}, 1'b1};
            end
            if (tb_wr) begin
                tb_q <= pwdata[TW-1:0];
            end else if (tb_tick) begin
                tb_q <= tb_q + {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end
    assign timer_a_count = ta_q;
    assign timer_b_count = tb_q;

    // Control byte with reserved bits as zero
    always @* begin
        ctrl_rd = `TSO_RESET_BYTE;
        ctrl_rd[`TSO_BIT_ENABLE] = sense_unit_enable_q;
        ctrl_rd[`TSO_BIT_RANGE_HI:`TSO_BIT_RANGE_LO] = osc_current_range_q;
        ctrl_rd[`TSO_BIT_DIR] = osc_direction_flag_q;
        ctrl_rd[`TSO_BIT_EXTSEL] = timer_a_ext_clock_select_q;
    end

    // Read data register, taken in setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `TSO_RESET_WORD;
        end else if (ce && rd && !penable) begin
            case (paddr)
                `TSO_ADDR_CTRL:  prdata <= {24'h000000, ctrl_rd};
                `TSO_ADDR_CHAN:  prdata <= {28'h0000000, sense_channel_code_q};
                `TSO_ADDR_TMR_A: prdata <= {{(32-TW){1'b0}}, ta_q};
                `TSO_ADDR_TMR_B: prdata <= {{(32-TW){1'b0}}, tb_q};
                `TSO_ADDR_TCFG:  prdata <= {27'h0000000, tb_run_q, ta_run_q,
                                            timer_b_clock_source_q, timer_a_clock_source_q};
                `TSO_ADDR_STAT:  prdata <= {30'h00000000, sleep, osc_active};
                default:         prdata <= `TSO_RESET_WORD;
            endcase
        end
    end
endmodule // tso_top

// File: verification/tso_assertions.sv
// Port checker for the touch sense oscillator control block
module tso_assertions #(
    parameter NCH = 12,
    parameter TW  = 16
) (
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic           sleep,
    input wire logic           osc_run,
    input wire logic [1:0]     osc_current_range,
    input wire logic [NCH-1:0] sense_input_pin,
    input wire logic [TW-1:0]  timer_a_count,
    input wire logic [TW-1:0]  timer_b_count
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded bus events
    wire          wr_e = psel && penable && pwrite;
    wire          unm  = (paddr > 12'h014) || (paddr[1:0] != 2'h0);
    wire [TW-1:0] wlo  = pwdata[TW-1:0];
    range_off_a: assert property (osc_current_range == 2'h0 |-> !osc_run)
        else $error("oscillator runs at range zero");
    one_hot_a: assert property ($onehot0(sense_input_pin))
        else $error("more than one sense input");
    chan_resv_a: assert property (wr_e && paddr == 12'h004 && pwdata[3:0] > 4'hb
        |-> ##2 sense_input_pin == 0) else $error("reserved code selects input");
    sleep_hold_a: assert property (sleep && $past(sleep) && !wr_e
        |=> $stable(timer_a_count)) else $error("timer a counts asleep");
    reset_zero_a: assert property ($rose(presetn) |-> timer_a_count == 0
        && timer_b_count == 0 && sense_input_pin == 0 && !osc_run) else $error("reset state");
    unm_read_a: assert property (psel && !penable && !pwrite && unm |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    tb_write_a: assert property (wr_e && paddr == 12'h00c |=> timer_b_count == $past(wlo))
        else $error("timer b write lost");
    bus_resp_a: assert property (psel && penable |-> pready && pslverr == unm)
        else $error("bad bus response");
    cover property (wr_e && paddr == 12'h00c);
    cover property (sleep && osc_run);
    cover property ($rose(osc_run));
endmodule // tso_assertions
bind tso_top tso_assertions #(.NCH(NCH), .TW(TW)) chk_u (.*);

// File: verification/tso_pad_model.sv
// Sense pad and analog oscillator stand-in
module tso_pad_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        osc_run,
    input  wire logic [11:0] sense_input_pin,
    input  wire logic        load,
    output logic             osc_wave,
    output wire logic        osc_sourcing
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // Wave runs whenever enabled with a pad, asleep or not; slower when loaded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= 4'h0;
            osc_wave <= 1'b0;
        end else if (osc_run && |sense_input_pin) begin
            cnt_q <= (cnt_q == (load ? 4'h5 : 4'h3)) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == (load ? 4'h5 : 4'h3)) osc_wave <= ~osc_wave;
        end
    end
    assign osc_sourcing = osc_wave;
endmodule // tso_pad_model

// File: verification/touch_sense_oscillator_control_bench.sv
// Self-checking bench for the touch sense oscillator control block
module touch_sense_oscillator_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sleep = 0, tpin = 0, load = 0, go = 0, er, sv;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rv;
    wire  [31:0] prdata;
    wire         pready, pslverr, osc_run, ow, os;
    wire  [1:0]  rng;
    wire  [11:0] pins;
    wire  [15:0] ta, tb;
    int          bad_count = 0, check_count = 0, seed = 32'hd088;
    int          cyc = 0, on = 0, pn = 0, cn = 0, v1, v2, i;
    tso_top #(.NCH(12), .TW(16)) dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep), .osc_wave(ow),
        .osc_sourcing(os), .timer_a_clock_pin(tpin), .osc_run(osc_run),
        .osc_current_range(rng), .sense_input_pin(pins), .timer_a_count(ta),
        .timer_b_count(tb));
    tso_pad_model pad_u (.pclk(pclk), .presetn(presetn), .osc_run(osc_run),
        .sense_input_pin(pins), .load(load), .osc_wave(ow), .osc_sourcing(os));
    // Clock
    initial forever #25 pclk = ~pclk;
    // Timeout, window cycle count and external pin clock
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out;
        end
        if (go) cn <= cn + 1;
        if (go && cyc % 3 == 0) tpin <= ~tpin;
    end
    // Reference edge counts
    always @(posedge ow) if (go) on++;
    always @(posedge tpin) if (go) pn++;
    task chk(input [31:0] s, input [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %0t seen %h want %h", $time, s, e);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task xf(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        sv = os;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function [31:0] pin_of(input [3:0] c, input en);
        pin_of = (en && c <= 4'hb) ? 32'h1 << c : 32'h0;
    endfunction
    function bit near(input [31:0] v, input int e);
        near = (v + 2 >= e) && (v <= e + 2);
    endfunction
    // Clear counter, run a fixed window, stop timers, read the count
    task meas(input [7:0] c, input [31:0] t, input [11:0] a, input s);
        xf(1, 12'h000, 8'h80); xf(1, 12'h004, 3); xf(1, 12'h010, t); xf(1, a, 0);
        on = 0; pn = 0; cn = 0; go <= 1; sleep <= s;
        xf(1, 12'h000, c);
        repeat (100) @(posedge pclk);
        xf(0, 12'h000, 0); chk(rv, {c[7:2], sv, c[0]});
        go <= 0;
        xf(1, 12'h010, 0);
        sleep <= 0;
        repeat (6) @(posedge pclk);
        xf(0, a, 0);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 24; i += 4) begin xf(0, i, 0); chk(rv, 0); end
        xf(1, 0, 32'hffff_ff7f); xf(0, 0, 0); chk(rv, 32'h0d);
        v1 = $random(seed);
        xf(1, 4, v1 | 32'hfff0); xf(0, 4, 0); chk(rv, v1 & 15);
        xf(0, 12'h018, 0); chk(rv, 0); chk(er, 1);
        $display("register test done");
        for (i = 0; i < 20; i++) begin
            v1 = i < 16 ? i : $random(seed);
            v2 = i != 18;
            xf(1, 0, {v2[0], 7'h04}); xf(1, 4, v1);
            @(posedge pclk); @(negedge pclk);
            chk(pins, pin_of(v1, v2)); chk(osc_run, v2);
        end
        for (i = 0; i < 4; i++) begin
            xf(1, 0, 8'h80 | i << 2); @(negedge pclk);
            chk(osc_run, i != 0); chk(rng, i);
        end
        $display("channel test done");
        v1 = $random(seed);
        xf(1, 12'h010, 0); xf(1, 12'h00c, v1); xf(0, 12'h00c, 0); chk(rv, v1 & 16'hffff);
        chk(tb, v1 & 16'hffff);
        meas(8'h8c, 32'h16, 12'h00c, 1); v1 = rv; chk(near(rv, on), 1);
        load <= 1;
        meas(8'h8c, 32'h16, 12'h00c, 0); v2 = rv; chk(near(rv, on), 1);
        chk(v2 < (v1 + v2) / 2, 1);
        load <= 0;
        meas(8'h8d, 32'h09, 12'h008, 0); chk(near(rv, on), 1);
        meas(8'h8c, 32'h09, 12'h008, 0); chk(near(rv, pn), 1);
        meas(8'h8d, 32'h09, 12'h008, 1); chk(rv, 0);
        meas(8'h8d, 32'h08, 12'h008, 0); chk(near(rv, cn / 4), 1);
        $display("timer test done");
        // Mid-run reset must bring every field back to zero
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        xf(0, 12'h000, 0); chk(rv, 0);
        xf(0, 12'h004, 0); chk(rv, 0);
        chk(ta, 0); chk(tb, 0);
        $display("reset test done");
        close_out;
    end
endmodule // touch_sense_oscillator_control_bench
